// ===== dpcr_pkg.sv
// Package with constants and types for the power, clock and reset controller.
package dpcr_pkg;

	// Register word offsets on the plain register port.
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h1;
	localparam logic [3:0] OFF_CMD = 4'h2;

	// Control register field positions.
	localparam int CTRL_PD_FORCE = 0;
	localparam int CTRL_CRYSTAL_PIN_OFF = 1;
	localparam int CTRL_CTX_CLEAR = 2;
	localparam int CTRL_CLKO_DIS = 3;
	localparam int CTRL_BOOT_EN = 4;

	// Command register field positions (write only, self clearing).
	localparam int CMD_IRQ_ON = 0;
	localparam int CMD_IRQ_OFF = 1;
	localparam int CMD_IDLE = 2;
	localparam int CMD_DIV_LSB = 3;
	localparam int CMD_DIV_MSB = 5;

	// Divisor codes carried by an idle command: 0 means plain idle.
	localparam logic [2:0] DIV_NONE = 3'h0;
	localparam logic [2:0] DIV_16 = 3'h1;
	localparam logic [2:0] DIV_32 = 3'h2;
	localparam logic [2:0] DIV_64 = 3'h3;
	localparam logic [2:0] DIV_128 = 3'h4;

	// Reset value of the control register.
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Wake-up timing in input clock cycles.
	localparam int WAKE_FAST_CYC = 200;
	localparam int WAKE_CRYSTAL_PIN_CYC = 4096;

	// Program address fetched first after reset or boot.
	localparam logic [13:0] START_ADDR = 14'h0000;

	// Controller states.
	typedef enum logic [5:0] {
		DPCR_BOOT = 6'b00_0001,
		DPCR_RUN = 6'b00_0010,
		DPCR_IDLE = 6'b00_0100,
		DPCR_PDOWN = 6'b00_1000,
		DPCR_WAKE = 6'b01_0000,
		DPCR_SLOW_EXIT = 6'b10_0000
	} dpcr_state_t;

endpackage

// ===== dpcr_ctl.sv
// Power, clock and reset controller for the signal processor core.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module dpcr_ctl #(
	parameter int CRYSTAL_PIN_WAIT = dpcr_pkg::WAKE_CRYSTAL_PIN_CYC,
	parameter int FAST_WAIT = dpcr_pkg::WAKE_FAST_CYC
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic powerdown_request_pin,
	output logic powerdown_ack_pin,
	input wire logic irq_pending,
	input wire logic dma_request,
	input wire logic bus_request,
	input wire logic pd_enter,
	input wire logic boot_done,
	output logic irq_service_en,
	output logic pd_irq,
	output logic dma_grant,
	output logic core_run,
	output logic context_clear,
	output logic core_clk_en,
	output logic processor_clock_output,
	output logic reset_core,
	output logic [13:0] fetch_addr,
	output logic boot_active
);

	// Elaboration check: the wake counter must hold both waits.
	if (CRYSTAL_PIN_WAIT < 1 || FAST_WAIT < 1 || CRYSTAL_PIN_WAIT > 65535 || FAST_WAIT > 65535) begin : g_chk
		$error("Wake wait counts out of range.");
	end

	// Two-flop synchroniser for the asynchronous power-down request pin.
	logic pdreq_s1_r;
	logic pdreq_s2_r;
	logic pdreq_prev_r;
	// Control register and command decode.
	logic [7:0] ctrl_r;
	logic irq_en_r;
	dpcr_pkg::dpcr_state_t state_r;
	dpcr_pkg::dpcr_state_t state_nxt;
	// Wake counter; the slow-idle prescaler has its own counter.
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic [2:0] div_r;
	logic [7:0] slow_cnt_r;
	logic processor_clock_output_r;
	logic [7:0] rdata_r;
	logic pd_irq_r;
	logic force_prev_r; // Force bit as it stood one cycle earlier.
	logic reset_done_r;

	// Turns a divisor code into the slow-idle clock ratio minus one.
	function automatic logic [7:0] div_limit(input logic [2:0] code);
		case (code)
			dpcr_pkg::DIV_16: div_limit = 8'h0F;
			dpcr_pkg::DIV_32: div_limit = 8'h1F;
			dpcr_pkg::DIV_64: div_limit = 8'h3F;
			dpcr_pkg::DIV_128: div_limit = 8'h7F;
			default: div_limit = 8'h00;
		endcase
	endfunction

	// Register and command decode.
	wire wr_ctrl = reg_wr && reg_addr == dpcr_pkg::OFF_CTRL;
	wire wr_cmd = reg_wr && reg_addr == dpcr_pkg::OFF_CMD;
	wire cmd_on = wr_cmd && reg_wdata[dpcr_pkg::CMD_IRQ_ON];
	wire cmd_off = wr_cmd && reg_wdata[dpcr_pkg::CMD_IRQ_OFF];
	wire cmd_idle = wr_cmd && reg_wdata[dpcr_pkg::CMD_IDLE];
	wire [2:0] cmd_div = reg_wdata[dpcr_pkg::CMD_DIV_MSB:dpcr_pkg::CMD_DIV_LSB];
	// Power-down request edge from the synchronised pin; the force bit is read from the control register.
	wire pd_edge = pdreq_s2_r && !pdreq_prev_r;
	wire pd_force = ctrl_r[dpcr_pkg::CTRL_PD_FORCE];
	wire crystal_pin_off = ctrl_r[dpcr_pkg::CTRL_CRYSTAL_PIN_OFF];
	wire [15:0] wake_len = crystal_pin_off ? 16'(CRYSTAL_PIN_WAIT - 1) : 16'(FAST_WAIT - 1);
	wire wake_done = cnt_r == wake_len;
	wire [7:0] slow_lim = div_limit(div_r);
	wire slow_tick = slow_cnt_r == slow_lim;
	wire irq_wake = irq_pending && irq_en_r;
	// State decode, shared by the sequencer, the outputs and the assertions.
	wire in_run = state_r == dpcr_pkg::DPCR_RUN;
	wire in_idle = state_r == dpcr_pkg::DPCR_IDLE;
	wire in_slow = state_r == dpcr_pkg::DPCR_SLOW_EXIT;
	wire in_pdown = state_r == dpcr_pkg::DPCR_PDOWN;
	wire in_wake = state_r == dpcr_pkg::DPCR_WAKE;
	// Only the rising edge of the force bit counts, so that a bit left set
	// does not flood the core with power-down interrupts.
	wire force_rise = pd_force && !force_prev_r;

	// Synchroniser and edge history for the request pin.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pdreq_s1_r <= 1'b0;
			pdreq_s2_r <= 1'b0;
			pdreq_prev_r <= 1'b0;
		end else if (clk_en) begin
			pdreq_s1_r <= powerdown_request_pin;
			pdreq_s2_r <= pdreq_s1_r;
			pdreq_prev_r <= pdreq_s2_r;
		end
	end

	// Control register; the force bit clears itself once power down is taken.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= dpcr_pkg::CTRL_RESET;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				ctrl_r <= reg_wdata;
			end else if (in_pdown) begin
				ctrl_r[dpcr_pkg::CTRL_PD_FORCE] <= 1'b0;
			end
		end
	end

	// Global interrupt servicing flag; the mask register is elsewhere.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_en_r <= 1'b1;
		end else if (clk_en) begin
			if (cmd_on) begin
				irq_en_r <= 1'b1;
			end else if (cmd_off) begin
				irq_en_r <= 1'b0;
			end
		end
	end

	// Power-down interrupt pulse, raised on the request edge or a force-bit rise in run, only while servicing is enabled.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_irq_r <= 1'b0;
			force_prev_r <= 1'b0;
		end else if (clk_en) begin
			pd_irq_r <= (pd_edge || (force_rise && in_run)) && irq_en_r;
			force_prev_r <= pd_force;
		end
	end

	// Next-state logic of the low-power sequencer.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			dpcr_pkg::DPCR_BOOT: begin
				// Boot only when configured and the bus is free.
				if (!ctrl_r[dpcr_pkg::CTRL_BOOT_EN] || (boot_done && !bus_request)) begin
					state_nxt = dpcr_pkg::DPCR_RUN;
				end
			end
			dpcr_pkg::DPCR_RUN: begin
				// The handler decides when to really go down.
				if (pd_enter) begin
					state_nxt = dpcr_pkg::DPCR_PDOWN;
				end else if (cmd_idle) begin
					state_nxt = dpcr_pkg::DPCR_IDLE;
				end
			end
			dpcr_pkg::DPCR_IDLE: begin
				if (irq_wake) begin
					state_nxt = (div_r == dpcr_pkg::DIV_NONE) ? dpcr_pkg::DPCR_RUN :
						dpcr_pkg::DPCR_SLOW_EXIT;
				end
			end
			dpcr_pkg::DPCR_SLOW_EXIT: begin
				// Wait out the current slow period, at most the divisor.
				if (slow_tick) begin
					state_nxt = dpcr_pkg::DPCR_RUN;
				end
			end
			dpcr_pkg::DPCR_PDOWN: begin
				if (pd_edge) begin
					state_nxt = dpcr_pkg::DPCR_WAKE;
					cnt_nxt = 16'h0000;
				end
			end
			dpcr_pkg::DPCR_WAKE: begin
				cnt_nxt = cnt_r + 16'h0001;
				if (wake_done) begin
					state_nxt = dpcr_pkg::DPCR_RUN;
				end
			end
			default: begin
				state_nxt = dpcr_pkg::DPCR_RUN;
			end
		endcase
	end

	// State, wake counter and divisor; reset always ends power down.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= dpcr_pkg::DPCR_BOOT;
			cnt_r <= 16'h0000;
			div_r <= dpcr_pkg::DIV_NONE;
		end else if (clk_en) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			if (cmd_idle && in_run) begin
				div_r <= cmd_div;
			end else if (state_nxt == dpcr_pkg::DPCR_RUN) begin
				div_r <= dpcr_pkg::DIV_NONE;
			end
		end
	end

	// Slow-idle prescaler: one enable per divisor period of the core clock.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			slow_cnt_r <= 8'h00;
		end else if (clk_en) begin
			slow_cnt_r <= slow_tick ? 8'h00 : slow_cnt_r + 8'h01;
		end
	end

	// Reset-release marker; the core stays in reset for one cycle after release.
	// No stabilisation wait is counted, since the input clock runs on through a later reset.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reset_done_r <= 1'b0;
		end else if (clk_en) begin
			reset_done_r <= 1'b1;
		end
	end

	// Clock output toggles on the instruction-clock enable, gated by the disable bit.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			processor_clock_output_r <= 1'b0;
		end else if (clk_en) begin
			if (ctrl_r[dpcr_pkg::CTRL_CLKO_DIS] || in_pdown) begin
				processor_clock_output_r <= 1'b0;
			end else if (core_clk_en) begin
				processor_clock_output_r <= !processor_clock_output_r;
			end
		end
	end

	// Read data, valid in the cycle after the read strobe.
	wire [7:0] status_word = {2'b00, state_r};
	wire [7:0] rd_mux = (reg_addr == dpcr_pkg::OFF_CTRL) ? ctrl_r :
		(reg_addr == dpcr_pkg::OFF_STATUS) ? {irq_en_r, status_word[6:0]} : 8'h00;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 8'h00;
		end else if (clk_en) begin
			rdata_r <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// Outputs.
	assign reg_rdata = rdata_r;
	assign powerdown_ack_pin = in_pdown;
	assign irq_service_en = irq_en_r;
	assign pd_irq = pd_irq_r;
	// Steals are granted in run and in both idle states, never by the global flag.
	assign dma_grant = dma_request && (in_run || in_idle || in_slow);
	assign core_run = in_run;
	assign context_clear = ctrl_r[dpcr_pkg::CTRL_CTX_CLEAR] && in_wake;
	// Slow idle runs the core clock at one enable per divisor.
	assign core_clk_en = (div_r == dpcr_pkg::DIV_NONE) ? !in_pdown : slow_tick;
	assign processor_clock_output = processor_clock_output_r;
	assign reset_core = !reset_done_r;
	assign fetch_addr = dpcr_pkg::START_ADDR;
	assign boot_active = state_r == dpcr_pkg::DPCR_BOOT;

	// Assertions; the rule that each one guards stands on its label line.
	irq_reset_a: assert property (@(posedge core_clk) $rose(arst_n) |-> irq_en_r)
		else $error("Servicing not enabled after reset.");
	irq_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && cmd_off && !cmd_on |=> !irq_service_en)
		else $error("Disable instruction ignored.");
	dma_run_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		in_run && dma_request |-> dma_grant)
		else $error("Steal refused while running.");
	ack_pd_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		powerdown_ack_pin |-> !core_run)
		else $error("Ack while running.");
	pd_enter_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && core_run && pd_enter |=> powerdown_ack_pin)
		else $error("Power down not entered.");
	wake_fast_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		in_pdown && pd_edge && clk_en && !crystal_pin_off && !wr_ctrl
		|-> ##[1:210] core_run || !clk_en)
		else $error("Fast wake too slow.");
	wake_ctx_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && in_pdown && pd_edge && !wr_ctrl && ctrl_r[dpcr_pkg::CTRL_CTX_CLEAR]
		|=> context_clear)
		else $error("Context clear missing in wake.");
	pd_irq_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && pd_edge && irq_en_r |=> pd_irq)
		else $error("Power-down interrupt missed.");
	force_irq_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && force_rise && in_run && irq_en_r |=> pd_irq)
		else $error("Force bit raised no interrupt.");
	idle_wake_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && in_idle && irq_wake && div_r == dpcr_pkg::DIV_NONE
		|=> core_run)
		else $error("Idle wake late.");
	dma_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		in_idle && dma_request |-> dma_grant)
		else $error("Steal refused in idle.");
	clko_dis_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		clk_en && ctrl_r[dpcr_pkg::CTRL_CLKO_DIS] |=> !processor_clock_output)
		else $error("Clock output not disabled.");
	slow_exit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		in_slow && clk_en |-> ##[0:128] core_run || !clk_en)
		else $error("Slow idle exit too long.");
	core_release_a: assert property (@(posedge core_clk)
		$rose(arst_n) && clk_en |=> !reset_core)
		else $error("Core held in reset after release.");
	pd_cover_c: cover property (@(posedge core_clk) powerdown_ack_pin ##1 in_wake);
	slow_cover_c: cover property (@(posedge core_clk) in_slow ##1 core_run);
	boot_cover_c: cover property (@(posedge core_clk) boot_active ##1 core_run);
	wake_cover_c: cover property (@(posedge core_clk) context_clear ##1 core_run);
	freeze_cover_c: cover property (@(posedge core_clk) !clk_en ##1 !clk_en);

endmodule
`default_nettype wire

// ===== dpcr_far.sv
// Far-side model: reset generator and power-down request source.
`timescale 1ns/1ns
`default_nettype none
module dpcr_far (
	input wire logic core_clk,
	output logic arst_n,
	output logic powerdown_request_pin
);
	// Reset is held low for a start-up span of clock cycles before release.
	task automatic hold_reset(input int n);
		arst_n <= 1'b0;
		repeat (n) @(posedge core_clk);
		arst_n <= 1'b1;
	endtask
	// The pin is a plain level; the block finds the edge itself.
	task automatic set_pin(input logic v);
		@(posedge core_clk);
		powerdown_request_pin <= v;
	endtask
	// Both lines start in their asserted and idle levels.
	initial begin
		arst_n = 1'b0;
		powerdown_request_pin = 1'b0;
	end
endmodule
`default_nettype wire

// ===== dpcr_ctl_tb.sv
// Self-checking bench for the power, clock and reset controller.
`timescale 1ns/1ns
`default_nettype none
module dpcr_ctl_tb;
	localparam int XW = 8; // Short crystal wait keeps the run brief.
	localparam int FW = 4; // Short running-clock wait.
	logic core_clk = 1'b0;
	wire logic arst_n, powerdown_request_pin;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr, reg_rd, irq_pending, dma_request;
	logic pd_enter, boot_done, bus_request, clk_en;
	wire logic [7:0] reg_rdata;
	wire logic [13:0] fetch_addr;
	wire logic powerdown_ack_pin, irq_service_en, pd_irq, dma_grant, core_run;
	wire logic context_clear, core_clk_en, processor_clock_output, reset_core, boot_active;
	int failures = 0, checked = 0, k, n, ww;
	logic cc, a, b;
	// Bench model of the status word.
	logic exp_irq;
	logic [5:0] exp_st;

	// The input clock never stops while the core runs.
	always #10 core_clk = ~core_clk;

	dpcr_ctl #(.CRYSTAL_PIN_WAIT(XW), .FAST_WAIT(FW)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
		.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .powerdown_request_pin(powerdown_request_pin),
		.powerdown_ack_pin(powerdown_ack_pin), .irq_pending(irq_pending),
		.dma_request(dma_request), .bus_request(bus_request), .pd_enter(pd_enter),
		.boot_done(boot_done), .irq_service_en(irq_service_en), .pd_irq(pd_irq),
		.dma_grant(dma_grant), .core_run(core_run), .context_clear(context_clear),
		.core_clk_en(core_clk_en), .processor_clock_output(processor_clock_output),
		.reset_core(reset_core), .fetch_addr(fetch_addr), .boot_active(boot_active));

	dpcr_far far_u (.core_clk(core_clk), .arst_n(arst_n),
		.powerdown_request_pin(powerdown_request_pin));

	// Compares one value and counts the result.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Moves one edge on and lets its updates land.
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask
	// One write cycle on the register port.
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// One read cycle; the data stand only in the following cycle.
	task automatic rd_chk(input logic [3:0] ad, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(32'(reg_rdata), 32'(e));
	endtask
	// Status and the enable flag against the bench model.
	task automatic status_chk();
		rd_chk(dpcr_pkg::OFF_STATUS, {exp_irq, 1'b0, exp_st});
		chk(32'(irq_service_en), 32'(exp_irq));
	endtask
	// Bounded waits; a limit reached shows up in the caller's comparison.
	task automatic wait_run(output int k, output logic cc);
		k = 0;
		cc = 1'b0;
		while (core_run !== 1'b1 && k < 400) begin
			step();
			k++;
			cc = cc | context_clear;
		end
	endtask
	task automatic wait_pdi(output int k);
		k = 0;
		while (pd_irq !== 1'b1 && k < 12) begin
			step();
			k++;
		end
	endtask
	task automatic done(input string s);
		$display("Test %s done", s);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("Summary: %0d checks, %0d failures", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// A hang is cut short well beyond the expected run length.
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		finish_test();
	end

	// Main sequence.
	initial begin
		k = $urandom(85);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		irq_pending <= 1'b0;
		dma_request <= 1'b0;
		pd_enter <= 1'b0;
		clk_en <= 1'b1;
		// Boot is not configured after reset, so random boot levels must not hold the core.
		boot_done <= 1'($urandom);
		bus_request <= 1'($urandom);
		exp_irq = 1'b1;
		exp_st = dpcr_pkg::DPCR_RUN;
		far_u.hold_reset(12);
		step();
		step();
		chk(32'(reset_core), 0);
		chk(32'(fetch_addr), 32'(dpcr_pkg::START_ADDR));
		chk(32'(boot_active), 0);
		status_chk();
		rd_chk(dpcr_pkg::OFF_CTRL, dpcr_pkg::CTRL_RESET);
		rd_chk(4'($urandom_range(15, 3)), 8'h00);
		done("reset");
		// With servicing off, a power-down request raises no interrupt.
		wr(dpcr_pkg::OFF_CMD, 8'h01 << dpcr_pkg::CMD_IRQ_OFF);
		exp_irq = 1'b0;
		status_chk();
		// Steals go on while servicing is globally off.
		@(posedge core_clk);
		dma_request <= 1'b1;
		#1;
		chk(32'(dma_grant), 1);
		@(posedge core_clk);
		dma_request <= 1'b0;
		far_u.set_pin(1'b1);
		wait_pdi(k);
		far_u.set_pin(1'b0);
		chk(32'(k), 12);
		wr(dpcr_pkg::OFF_CMD, 8'h01 << dpcr_pkg::CMD_IRQ_ON);
		exp_irq = 1'b1;
		status_chk();
		done("irq");
		// Plain idle, then every divisor; the period of the clock enable is the divisor.
		for (int c = 0; c < 5; c++) begin
			n = (c == 0) ? 1 : (8 << c);
			wr(dpcr_pkg::OFF_CMD, 8'((c << dpcr_pkg::CMD_DIV_LSB) | (1 << dpcr_pkg::CMD_IDLE)));
			exp_st = dpcr_pkg::DPCR_IDLE;
			status_chk();
			@(posedge core_clk);
			dma_request <= 1'b1;
			#1;
			chk(32'(dma_grant), 1);
			chk(32'(core_run), 0);
			wait_pdi(k);
			k = 0;
			while (core_clk_en !== 1'b1 && k < 300) begin
				step();
				k++;
			end
			k = 0;
			do begin
				step();
				k++;
			end while (core_clk_en !== 1'b1 && k < 300);
			chk(32'(k), 32'(n));
			repeat ($urandom_range(4, 0)) @(posedge core_clk);
			// One interrupt per idle, so the source never outpaces the wake-up.
			@(posedge core_clk);
			irq_pending <= 1'b1;
			dma_request <= 1'b0;
			wait_run(k, cc);
			chk(32'(k <= n + 1), 1);
			@(posedge core_clk);
			irq_pending <= 1'b0;
			exp_st = dpcr_pkg::DPCR_RUN;
		end
		done("idle");
		// The clock output toggles with each instruction clock unless disabled.
		for (int m = 0; m < 2; m++) begin
			wr(dpcr_pkg::OFF_CTRL, m ? 8'h08 : 8'h00);
			step();
			a = processor_clock_output;
			step();
			b = processor_clock_output;
			chk(32'(a ^ b), 32'(m == 0));
			chk(32'(a & (m == 1)), 0);
		end
		// A low clock enable freezes the clock output along with all other state.
		wr(dpcr_pkg::OFF_CTRL, 8'h00);
		@(posedge core_clk);
		clk_en <= 1'b0;
		step();
		a = processor_clock_output;
		step();
		chk(32'(processor_clock_output), 32'(a));
		@(posedge core_clk);
		clk_en <= 1'b1;
		done("processor_clock_output");
		// Power down by pin (running clock, then crystal off) and by force bit.
		for (int m = 0; m < 3; m++) begin
			ww = (m == 1) ? XW : FW;
			wr(dpcr_pkg::OFF_CTRL, (m == 1) ? 8'h06 : 8'h00);
			if (m == 2) begin
				wr(dpcr_pkg::OFF_CTRL, 8'h01);
			end else begin
				far_u.set_pin(1'b1);
			end
			wait_pdi(k);
			far_u.set_pin(1'b0);
			chk(32'(k < 12), 1);
			#1;
			chk(32'(pd_irq), 0);
			@(posedge core_clk);
			pd_enter <= 1'b1;
			@(posedge core_clk);
			pd_enter <= 1'b0;
			#1;
			chk(32'(powerdown_ack_pin), 1);
			chk(32'(core_clk_en), 0);
			exp_st = dpcr_pkg::DPCR_PDOWN;
			status_chk();
			rd_chk(dpcr_pkg::OFF_CTRL, (m == 1) ? 8'h06 : 8'h00);
			exp_st = dpcr_pkg::DPCR_RUN;
			if (m < 2) begin
				far_u.set_pin(1'b1);
				wait_run(k, cc);
				far_u.set_pin(1'b0);
				chk(32'(k >= ww + 2 && k <= ww + 5), 1);
				chk(32'(cc), 32'(m == 1));
			end else begin
				far_u.hold_reset(2);
				#1;
				chk(32'(powerdown_ack_pin), 0);
				step();
				status_chk();
				rd_chk(dpcr_pkg::OFF_CTRL, dpcr_pkg::CTRL_RESET);
			end
		end
		done("powerdown");
		finish_test();
	end
endmodule
`default_nettype wire
